//--- logic/lane_map_pkg.sv
// shared constants, types and format table for the sample-to-lane mapper
package lane_map_pkg;

  localparam int SAMPLE_W    = 9;
  localparam int NUM_CH      = 4;
  localparam int NUM_LANES   = 8;
  localparam int OCTET_W     = 8;
  localparam int FRAME_W     = 64;
  localparam int MAX_SLOTS   = 5;
  localparam int FIFO_DEPTH  = 16;
  localparam int SBUF_DEPTH  = 20;
  localparam int SLOT_FULL_W = 12;

  localparam logic [3:0] FMT_7  = 4'h7;
  localparam logic [3:0] FMT_8  = 4'h8;
  localparam logic [3:0] FMT_9  = 4'h9;
  localparam logic [3:0] FMT_10 = 4'ha;
  localparam logic [3:0] FMT_11 = 4'hb;
  localparam logic [3:0] FMT_RESET = 4'h7;

  localparam logic [7:0] LANES_NONE = 8'h00;

  typedef enum logic [1:0] {
    PART_SINGLE,
    PART_DUAL,
    PART_QUAD,
    PART_NONE
  } part_e;

  // one sample of every channel, channel a in the low slice
  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } sample_word_s;

  typedef struct packed {
    logic                            valid;
    logic                            frame_start;
    logic [NUM_LANES-1:0]            lane_en;
    logic [NUM_LANES-1:0][OCTET_W-1:0] octet;
  } lane_out_s;

  typedef struct packed {
    logic       ok;
    logic [2:0] lanes_per_ch;
    logic [3:0] slot_w;
    logic [2:0] slots;
    logic [3:0] octets;
    logic [4:0] samples;
  } fmt_info_s;

  function automatic fmt_info_s fmt_info(input logic [3:0] fmt);
    fmt_info_s f;
    f = '{1'b0, 3'd1, 4'd8, 3'd1, 4'd1, 5'd1};
    case (fmt)
      FMT_7:   f = '{1'b1, 3'd1, 4'd8,  3'd1, 4'd1, 5'd1};
      FMT_8:   f = '{1'b1, 3'd1, 4'd12, 3'd2, 4'd3, 5'd2};
      FMT_9:   f = '{1'b1, 3'd2, 4'd8,  3'd1, 4'd1, 5'd2};
      FMT_10:  f = '{1'b1, 3'd2, 4'd10, 3'd4, 4'd5, 5'd8};
      FMT_11:  f = '{1'b1, 3'd4, 4'd12, 3'd5, 4'd8, 5'd20};
      default: f.ok = 1'b0;
    endcase
    return f;
  endfunction

  function automatic logic [2:0] part_channels(input part_e p);
    case (p)
      PART_SINGLE: return 3'd1;
      PART_DUAL:   return 3'd2;
      PART_QUAD:   return 3'd4;
      default:     return 3'd0;
    endcase
  endfunction

endpackage

//--- logic/sample_fifo.sv
// parameterised valid/ready fifo in front of the lane mapper
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          full;
    logic          room;
    logic          empty;
  } fifo_state_s;

  fifo_state_s      st_reg;
  fifo_state_s      st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // full and empty kept as flops so ready/valid are clean
  assign push     = wr_valid & ~st_reg.full;
  assign pop      = rd_ready & ~st_reg.empty;
  assign wr_ready = st_reg.room;
  assign rd_valid = ~st_reg.empty;
  assign rd_data  = mem[st_reg.rp];

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt   = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    st_next.full  = st_next.cnt == (AW+1)'(DEPTH);
    st_next.room  = ~st_next.full;
    st_next.empty = st_next.cnt == '0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, room: 1'b1,
                  empty: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[st_reg.wp] <= wr_data;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_reg.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  c_fifo_fills: cover property (@(posedge ref_clk) disable iff (sys_rst)
    st_reg.full);
endmodule
`default_nettype wire

//--- logic/sample_to_lane_mapper.sv
// packs converter samples into lane octets for link formats 7 to 11
`timescale 1ns/1ps
`default_nettype none
module sample_to_lane_mapper
  import lane_map_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // configuration
  input  wire logic [3:0]   link_format_select,
  input  wire part_e        part_kind,
  input  wire logic         link_en,
  // sample stream
  input  wire logic         smp_valid,
  output logic              smp_ready,
  input  wire sample_word_s smp_data,
  // lane side
  output lane_out_s         lane_out,
  output logic              fmt_error,
  output logic              fmt_changed
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_BUILD,
    ST_EMIT
  } map_state_e;

  typedef struct packed {
    map_state_e                       st;
    logic [3:0]                       fmt;
    part_e                            part;
    logic [4:0]                       sidx;
    logic [3:0]                       oidx;
    logic [NUM_LANES-1:0]             lane_mask;
    logic [NUM_LANES-1:0][FRAME_W-1:0] frame;
    lane_out_s                        out;
    logic                             err;
    logic                             chg;
  } mapper_state_s;

  mapper_state_s s_reg;
  mapper_state_s s_next;

  sample_word_s  sbuf [SBUF_DEPTH];
  sample_word_s  fifo_data;
  logic          fifo_valid;
  logic          fifo_pop;
  fmt_info_s     info;
  fmt_info_s     info_in;
  logic [NUM_LANES-1:0][FRAME_W-1:0] frame_build;
  logic [NUM_LANES-1:0] mask_in;

  // fifo decouples the converter burst from frame assembly
  sample_fifo #(
    .WIDTH ($bits(sample_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .wr_valid (smp_valid),
    .wr_ready (smp_ready),
    .wr_data  (smp_data),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_data)
  );

  assign info     = fmt_info(s_reg.fmt);
  assign info_in  = fmt_info(link_format_select);
  // pop only while the link runs, else a word is lost on link drop
  assign fifo_pop = fifo_valid && link_en
                    && s_reg.st == ST_COLLECT;

  // lanes in use: channels present times lanes per channel
  always_comb begin
    logic [3:0] used;
    used    = 4'(part_channels(part_kind)) * {1'b0, info_in.lanes_per_ch};
    mask_in = LANES_NONE;
    for (int l = 0; l < NUM_LANES; l++) begin
      if (4'(l) < used) begin
        mask_in[l] = 1'b1;
      end
    end
  end

  // slot packing, msb first; slot k of lane j holds sample j + k*lpc
  always_comb begin
    logic [SLOT_FULL_W-1:0] sv;
    logic [SAMPLE_W-1:0]    smp;
    int                     ch;
    int                     j;
    int                     idx;
    int                     off;
    sv          = '0;
    smp         = '0;
    ch          = 0;
    j           = 0;
    idx         = 0;
    off         = 0;
    frame_build = '0;
    for (int l = 0; l < NUM_LANES; l++) begin
      ch = l / int'(info.lanes_per_ch);
      j  = l % int'(info.lanes_per_ch);
      for (int k = 0; k < MAX_SLOTS; k++) begin
        idx = j + k * int'(info.lanes_per_ch);
        off = k * int'(info.slot_w);
        if (k < int'(info.slots) && ch < NUM_CH && idx < SBUF_DEPTH) begin
          smp = sbuf[idx].ch[ch];
          if (info.slot_w == 4'd8) begin
            sv = {smp[SAMPLE_W-1:1], 4'h0};
          end else begin
            // trailing zeros of a slot, tail nibble stays zero
            sv = {smp, 3'b000};
          end
          frame_build[l] = frame_build[l]
                           | ({sv, 52'h0} >> off);
        end
      end
    end
  end

  always_comb begin
    s_next           = s_reg;
    s_next.out.valid = 1'b0;
    s_next.out.frame_start = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.chg = 1'b0;
        if (link_en) begin
          // format and part caught once, at link start
          s_next.fmt       = link_format_select;
          s_next.part      = part_kind;
          s_next.lane_mask = mask_in;
          s_next.sidx      = '0;
          if (info_in.ok && part_kind != PART_NONE
              && !(link_format_select == FMT_11
                   && part_kind == PART_QUAD)) begin
            s_next.err = 1'b0;
            s_next.st  = ST_COLLECT;
          end else begin
            s_next.err = 1'b1;
          end
        end else begin
          s_next.err = 1'b0;
        end
      end
      ST_COLLECT: begin
        if (!link_en) begin
          s_next.st = ST_IDLE;
        end else if (fifo_pop) begin
          s_next.sidx = s_reg.sidx + 5'd1;
          if (s_reg.sidx == info.samples - 5'd1) begin
            s_next.st = ST_BUILD;
          end
        end
      end
      ST_BUILD: begin
        s_next.frame = frame_build;
        s_next.oidx  = '0;
        s_next.st    = ST_EMIT;
      end
      ST_EMIT: begin
        s_next.out.valid       = 1'b1;
        s_next.out.frame_start = s_reg.oidx == 4'd0;
        s_next.out.lane_en     = s_reg.lane_mask;
        for (int l = 0; l < NUM_LANES; l++) begin
          s_next.out.octet[l] = s_reg.lane_mask[l]
            ? s_reg.frame[l][FRAME_W-1 - 8*int'(s_reg.oidx) -: OCTET_W]
            : 8'h00;
        end
        s_next.oidx = s_reg.oidx + 4'd1;
        if (s_reg.oidx == info.octets - 4'd1) begin
          s_next.sidx = '0;
          // a frame in flight always completes before link drop
          s_next.st   = link_en ? ST_COLLECT : ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    // selection change while running is ignored but reported
    if (s_reg.st != ST_IDLE && link_format_select != s_reg.fmt) begin
      s_next.chg = 1'b1;
    end
    if (!s_next.out.valid) begin
      s_next.out.lane_en = LANES_NONE;
      s_next.out.octet   = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg      <= '0;
      s_reg.st   <= ST_IDLE;
      s_reg.fmt  <= FMT_RESET;
      s_reg.part <= PART_SINGLE;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (fifo_pop) begin
      sbuf[s_reg.sidx] <= fifo_data;
    end
  end

  assign lane_out    = s_reg.out;
  assign fmt_error   = s_reg.err;
  assign fmt_changed = s_reg.chg;

  // stale octets on a masked lane would reach the far end as data
  logic [NUM_LANES-1:0] quiet_bad;
  always_comb begin
    for (int l = 0; l < NUM_LANES; l++) begin
      quiet_bad[l] = !lane_out.lane_en[l] && lane_out.octet[l] != 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_fmt7_one_octet: assert property (
    lane_out.frame_start && s_reg.fmt == FMT_7 |=> !lane_out.valid)
    else $error("format 7 frame longer than one octet");
  a_lane_mask_part: assert property (
    lane_out.valid && s_reg.fmt == FMT_7 && s_reg.part == PART_DUAL
    |-> lane_out.lane_en == 8'h03)
    else $error("dual part lane mask wrong in format 7");
  a_fmt8_three_oct: assert property (
    lane_out.frame_start && s_reg.fmt == FMT_8
    |-> lane_out.valid[*3] ##1 !lane_out.valid)
    else $error("format 8 frame not three octets");
  a_fmt9_lane_pairs: assert property (
    lane_out.valid && s_reg.fmt == FMT_9 && s_reg.part == PART_SINGLE
    |-> lane_out.lane_en == 8'h03)
    else $error("format 9 single part must use two lanes");
  a_quad_eight_lanes: assert property (
    lane_out.valid && s_reg.part == PART_QUAD
    && (s_reg.fmt == FMT_9 || s_reg.fmt == FMT_10)
    |-> lane_out.lane_en == 8'hff)
    else $error("quad part must fill all eight lanes");
  a_fmt10_five_oct: assert property (
    lane_out.frame_start && s_reg.fmt == FMT_10
    |-> lane_out.valid[*5] ##1 !lane_out.valid)
    else $error("format 10 frame not five octets");
  a_fmt11_no_quad: assert property (
    lane_out.valid |-> !(s_reg.fmt == FMT_11 && s_reg.part == PART_QUAD))
    else $error("format 11 emitted on a quad part");
  a_fmt11_tail: assert property (
    lane_out.frame_start && s_reg.fmt == FMT_11
    |-> ##7 (lane_out.valid && lane_out.octet[0][3:0] == 4'h0
             && lane_out.octet[7][3:0] == 4'h0))
    else $error("format 11 tail nibble not zero");
  a_fmt_held: assert property (
    s_reg.st != ST_IDLE |=> $stable(s_reg.fmt))
    else $error("format changed while running");
  a_quiet_lanes: assert property (
    lane_out.valid |-> quiet_bad == LANES_NONE)
    else $error("inactive lane carries data");
  a_start_valid: assert property (
    lane_out.frame_start |-> lane_out.valid)
    else $error("frame start without valid octet");
  a_fmt7_quad_lanes: assert property (
    lane_out.valid && s_reg.fmt == FMT_7 && s_reg.part == PART_QUAD
    |-> lane_out.lane_en == 8'h0f)
    else $error("quad part lane mask wrong in format 7");
  a_fmt9_one_oct: assert property (
    lane_out.frame_start && s_reg.fmt == FMT_9 |=> !lane_out.valid)
    else $error("format 9 frame longer than one octet");
  a_fmt10_pairs: assert property (
    lane_out.valid && s_reg.fmt == FMT_10 && s_reg.part == PART_DUAL
    |-> lane_out.lane_en == 8'h0f)
    else $error("format 10 dual part must use four lanes");
  a_fmt11_eight_oct: assert property (
    lane_out.frame_start && s_reg.fmt == FMT_11
    |-> lane_out.valid[*8] ##1 !lane_out.valid)
    else $error("format 11 frame not eight octets");
  a_fmt11_dual_lanes: assert property (
    lane_out.valid && s_reg.fmt == FMT_11 && s_reg.part == PART_DUAL
    |-> lane_out.lane_en == 8'hff)
    else $error("format 11 dual part must use eight lanes");
  a_error_quiet: assert property (
    fmt_error |-> !lane_out.valid)
    else $error("frame sent while format refused");

  c_fmt7_frame: cover property (lane_out.frame_start && s_reg.fmt == FMT_7);
  c_fmt11_frame: cover property (
    lane_out.frame_start && s_reg.fmt == FMT_11);
  c_fmt_error: cover property (fmt_error);
  c_fmt_changed: cover property (fmt_changed);
endmodule
`default_nettype wire

//--- verif/lane_receiver.sv
// far-end receiver model that captures whole lane frames
`timescale 1ns/1ps
`default_nettype none
module lane_receiver
  import lane_map_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // lane side
  input  wire lane_out_s  lane_out,
  // last completed frame
  output int              frames,
  output logic [7:0][63:0] bits,
  output int              octets,
  output logic [7:0]      lanes
);
  logic [7:0][63:0] acc;
  int               n;
  logic             busy;

  // frame alignment follows frame_start; format is fixed per run
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      frames <= 0;
      busy <= 1'b0;
      n <= 0;
    end else if (lane_out.valid) begin
      for (int l = 0; l < 8; l++)
        acc[l] <= lane_out.frame_start ? 64'(lane_out.octet[l])
                  : {acc[l][55:0], lane_out.octet[l]};
      n <= lane_out.frame_start ? 1 : n + 1;
      busy <= 1'b1;
      if (lane_out.frame_start)
        lanes <= lane_out.lane_en;
    end else if (busy) begin
      // left-align so short frames compare like long ones
      for (int l = 0; l < 8; l++)
        bits[l] <= acc[l] << (64 - 8 * n);
      octets <= n;
      frames <= frames + 1;
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verif/test_sample_to_lane_mapper.sv
// self-checking bench for the sample-to-lane mapper
`timescale 1ns/1ps
`default_nettype none
module test_sample_to_lane_mapper
  import lane_map_pkg::*;
;
  logic             ref_clk;
  logic             sys_rst;
  logic [3:0]       link_format_select;
  part_e            part_kind;
  logic             link_en;
  logic             smp_valid;
  logic             smp_ready;
  sample_word_s     smp_data;
  lane_out_s        lane_out;
  logic             fmt_error;
  logic             fmt_changed;
  int               rx_frames;
  logic [7:0][63:0] rx_bits;
  int               rx_octets;
  logic [7:0]       rx_lanes;
  int               num_errors;
  int               comparisons;
  int               seed;
  int               nfr;
  int               cyc;
  sample_word_s     words [40];
  int lpt[5] = '{1, 1, 2, 2, 4};
  int slt[5] = '{1, 2, 1, 4, 5};
  int wt[5]  = '{8, 12, 8, 10, 12};
  int bf[3]  = '{11, 12, 7};
  int bp[3]  = '{2, 0, 3};

  sample_to_lane_mapper uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .link_format_select(link_format_select), .part_kind(part_kind),
    .link_en(link_en), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .lane_out(lane_out), .fmt_error(fmt_error),
    .fmt_changed(fmt_changed)
  );
  lane_receiver rx (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .lane_out(lane_out),
    .frames(rx_frames), .bits(rx_bits), .octets(rx_octets),
    .lanes(rx_lanes)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task close_out;
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      close_out;
    end
  end

  task cmp(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // 8-bit formats carry the top 8 of 9 bits; zero pads follow
  function automatic logic [63:0] expv(input int f, p, l, b);
    int lp, s, w, c, j;
    logic [63:0] v, y;
    lp = lpt[f-7];
    s = slt[f-7];
    w = wt[f-7];
    c = l / lp;
    j = l % lp;
    v = '0;
    if (c >= (p == 0 ? 1 : p * 2))
      return '0;
    for (int i = 0; i < s; i++) begin
      y = 64'(words[b + j + i * lp].ch[c]);
      v = (v << w) | (w == 8 ? y >> 1 : y << (w - 9));
    end
    return v << (64 - s * w);
  endfunction

  task newwords;
    for (int i = 0; i < 40; i++)
      words[i] = 36'({$random(seed), $random(seed)});
  endtask

  task push(input sample_word_s w);
    int t;
    smp_valid <= 1'b1;
    smp_data <= w;
    t = 0;
    do begin
      @(negedge ref_clk);
      t++;
    end while (smp_ready !== 1'b1 && t < 300);
    if (smp_ready !== 1'b1)
      num_errors++;
    @(posedge ref_clk);
  endtask

  task getf(input int f, p, b);
    int t, lp, n;
    t = 0;
    lp = lpt[f-7];
    n = p == 0 ? 1 : p * 2;
    while (rx_frames <= nfr && t < 500) begin
      @(negedge ref_clk);
      t++;
    end
    if (rx_frames <= nfr)
      num_errors++;
    nfr++;
    cmp(rx_lanes, (64'd1 << (n * lp)) - 1);
    cmp(rx_octets, (slt[f-7] * wt[f-7] + 7) / 8);
    for (int l = 0; l < 8; l++)
      cmp(rx_bits[l], expv(f, p, l, b));
  endtask

  task run(input int f, p, nf, pre, chg);
    int spf;
    spf = slt[f-7] * lpt[f-7];
    link_format_select <= 4'(f);
    part_kind <= part_e'(p);
    link_en <= 1'b1;
    @(posedge ref_clk);
    if (chg) begin
      link_format_select <= 4'(f + 1);
      repeat (2) @(posedge ref_clk);
    end
    fork
      begin
        for (int i = pre; i < nf * spf; i++)
          push(words[i]);
        smp_valid <= 1'b0;
      end
      for (int k = 0; k < nf; k++)
        getf(f, p, k * spf);
    join
    if (chg)
      cmp(fmt_changed, 1);
    else
      cmp(fmt_changed, 0);
    cmp(fmt_error, 0);
    link_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  initial begin
    seed = 97;
    num_errors = 0;
    comparisons = 0;
    nfr = 0;
    cyc = 0;
    sys_rst = 1'b1;
    link_en = 1'b0;
    smp_valid = 1'b0;
    smp_data = '0;
    link_format_select = FMT_7;
    part_kind = PART_SINGLE;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int f = 7; f < 12; f++)
      for (int p = 0; p < 3; p++)
        if (!(f == 11 && p == 2)) begin
          newwords;
          run(f, p, 2, 0, 0);
        end
    newwords;
    run(7, 1, 1, 0, 1);
    // fill the fifo until it refuses, then drain with the link
    newwords;
    for (int i = 0; i < 16; i++)
      push(words[i]);
    smp_data <= words[16];
    @(negedge ref_clk);
    cmp(smp_ready, 0);
    @(posedge ref_clk);
    smp_valid <= 1'b0;
    run(10, 2, 2, 16, 0);
    // refused combinations give no frames
    for (int i = 0; i < 3; i++) begin
      link_format_select <= 4'(bf[i]);
      part_kind <= part_e'(bp[i]);
      link_en <= 1'b1;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp(fmt_error, 1);
      cmp(rx_frames, nfr);
      @(posedge ref_clk);
      link_en <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    close_out;
  end
endmodule
`default_nettype wire
